/* File: shared/serial_eeprom_regs.vh */
`ifndef SERIAL_EEPROM_REGS_VH
`define SERIAL_EEPROM_REGS_VH
// How it works
// - Counter holds last accessed address plus one
// - Counter kept between operations while powered
// - Read wrap: last byte to first byte
// - Write wrap stays within current page
// - After read-select ack, shift out current data
// - Random read returns data at loaded address
// - Each master ack increments, sends next word
// - Sequential read wraps at top, continues
// - Eighth address bit selects read or write
// - Match drives ack low; mismatch goes standby
// - Top four address bits hold type pattern
// - Page bits form upper word address bits

// ------------------------------------------------
// Address word layout and constants
// ------------------------------------------------
`define DEV_TYPE_CODE 4'hA
`define DEV_TYPE_MSB 7
`define DEV_TYPE_LSB 4
`define DEV_RW_BIT 0
`define ADDR_RESET 11'h000
`define FIFO_DEPTH_DEF 8
`endif

/* File: logic/byte_fifo.v */
`timescale 1ns/1ps
module byte_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    // Clock and reset
    input wire clk_i,
    input wire arst_n_i,
    input wire flush_i,
    // Fill side
    input wire in_valid_i,
    output wire in_ready_o,
    input wire [WIDTH-1:0] in_data_i,
    // Drain side
    output wire out_valid_o,
    input wire out_ready_i,
    output wire [WIDTH-1:0] out_data_o
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_r;
    reg [AW-1:0] rd_ptr_r;
    reg [AW:0] count_r;
    wire push;
    wire pop;

    assign in_ready_o = (count_r != DEPTH[AW:0]);
    assign out_valid_o = (count_r != {(AW+1){1'b0}});
    assign out_data_o = mem[rd_ptr_r];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data_i;
        end
    end

    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wr_ptr_r <= {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            count_r <= {(AW+1){1'b0}};
        end else if (flush_i) begin
            wr_ptr_r <= {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            count_r <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == DEPTH[AW-1:0] - 1'b1) ?
                    {AW{1'b0}} : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == DEPTH[AW-1:0] - 1'b1) ?
                    {AW{1'b0}} : rd_ptr_r + 1'b1;
            end
            if (push && !pop) begin
                count_r <= count_r + 1'b1;
            end else if (pop && !push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end
endmodule // byte_fifo

/* File: logic/eeprom_read_engine.v */
`timescale 1ns/1ps
`include "serial_eeprom_regs.vh"
module eeprom_read_engine #(
    parameter AW = 11,
    parameter PAGE_BITS = 4,
    parameter PAGE_SEL_BITS = 3,
    parameter FIFO_DEPTH = `FIFO_DEPTH_DEF
) (
    // Clock and reset
    input wire clk_i,
    input wire arst_n_i,
    // Two-wire bus pins
    input wire scl_i,
    input wire sda_i,
    output reg sda_o,
    output reg sda_oe_o,
    // Hard-wired device address pins
    input wire [2:0] chip_sel_i,
    // Memory array read port
    output reg [AW-1:0] mem_addr_o,
    output reg mem_rd_o,
    input wire [7:0] mem_data_i,
    // Memory array write stream
    output reg wr_valid_o,
    output reg [AW-1:0] wr_addr_o,
    output reg [7:0] wr_data_o,
    input wire wr_ready_i,
    // Status
    output reg busy_o,
    output reg [AW-1:0] addr_cnt_o
);
    localparam ST_IDLE = 3'h0;
    localparam ST_DEVADR = 3'h1;
    localparam ST_ACK = 3'h2;
    localparam ST_WADDR = 3'h3;
    localparam ST_WDATA = 3'h4;
    localparam ST_RDATA = 3'h5;
    localparam ST_MACK = 3'h6;
    localparam ST_FETCH = 3'h7;
    localparam LOW_BITS = AW - PAGE_SEL_BITS;
    localparam FIFO_AW = $clog2(FIFO_DEPTH);

    // ------------------------------------------------
    // Pin synchronisers and edge detection
    // ------------------------------------------------
    // Two stages tame metastability; the third keeps the last level
    reg scl_m_r, scl_s_r, scl_d_r;
    reg sda_m_r, sda_s_r, sda_d_r;
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            scl_m_r <= 1'b1;
            scl_s_r <= 1'b1;
            scl_d_r <= 1'b1;
            sda_m_r <= 1'b1;
            sda_s_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_m_r <= scl_i;
            scl_s_r <= scl_m_r;
            scl_d_r <= scl_s_r;
            sda_m_r <= sda_i;
            sda_s_r <= sda_m_r;
            sda_d_r <= sda_s_r;
        end
    end
    wire scl_rise = scl_s_r && !scl_d_r;
    wire scl_fall = !scl_s_r && scl_d_r;
    // Data moving while clock is high marks start or stop
    wire start_ev = scl_s_r && scl_d_r && sda_d_r && !sda_s_r;
    wire stop_ev = scl_s_r && scl_d_r && !sda_d_r && sda_s_r;

    // ------------------------------------------------
    // Address helpers
    // ------------------------------------------------
    function [AW-1:0] read_next;
        input [AW-1:0] a;
        begin
            read_next = a + 1'b1;
        end
    endfunction

    function [AW-1:0] write_next;
        input [AW-1:0] a;
        begin
            // Only the in-page bits count, the page row is kept
            write_next = {a[AW-1:PAGE_BITS],
                          a[PAGE_BITS-1:0] + 1'b1};
        end
    endfunction

    // ------------------------------------------------
    // Device address decode
    // ------------------------------------------------
    // Strapped bits above the page bits must match their pins; the
    // widest array uses all three as page bits and strapping is moot
    function dev_match;
        input [7:0] w;
        input [2:0] pins;
        integer i;
        begin
            dev_match = (w[`DEV_TYPE_MSB:`DEV_TYPE_LSB] == `DEV_TYPE_CODE);
            for (i = 0; i < 3; i = i + 1) begin
                if (i >= PAGE_SEL_BITS && w[i+1] != pins[i]) begin
                    dev_match = 1'b0;
                end
            end
        end
    endfunction

    // Write data leaves through a FIFO so the array may stall us
    reg fifo_in_valid_r;
    reg [AW+7:0] fifo_in_data_r;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [AW+7:0] fifo_out_data;
    wire fifo_take = fifo_out_valid && (!wr_valid_o || wr_ready_i);

    byte_fifo #(
        .WIDTH(AW + 8),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_wr_fifo (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .flush_i(1'b0),
        .in_valid_i(fifo_in_valid_r),
        .in_ready_o(fifo_in_ready),
        .in_data_i(fifo_in_data_r),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_take),
        .out_data_o(fifo_out_data)
    );

    // ------------------------------------------------
    // Protocol state machine
    // ------------------------------------------------
    reg [2:0] state_r;
    reg [3:0] bit_cnt_r;
    reg [7:0] shift_r;
    reg [7:0] tx_r;
    reg [1:0] ack_next_r;
    reg [AW-1:0] addr_r;
    // Page bits of the address byte stand above the counter's low bits
    wire [AW-1:0] sel_addr = {shift_r[PAGE_SEL_BITS:1],
                              addr_r[LOW_BITS-1:0]};

    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_r <= ST_IDLE;
            bit_cnt_r <= 4'h0;
            shift_r <= 8'h00;
            tx_r <= 8'hFF;
            ack_next_r <= 2'h0;
            addr_r <= `ADDR_RESET;
            sda_o <= 1'b0;
            sda_oe_o <= 1'b0;
            mem_addr_o <= `ADDR_RESET;
            mem_rd_o <= 1'b0;
            fifo_in_valid_r <= 1'b0;
            fifo_in_data_r <= {(AW+8){1'b0}};
            busy_o <= 1'b0;
            addr_cnt_o <= `ADDR_RESET;
        end else begin
            mem_rd_o <= 1'b0;
            sda_o <= 1'b0;
            if (fifo_in_valid_r && fifo_in_ready) begin
                fifo_in_valid_r <= 1'b0;
            end
            busy_o <= (state_r != ST_IDLE);
            addr_cnt_o <= addr_r;
            if (stop_ev) begin
                // Counter is left untouched between operations
                state_r <= ST_IDLE;
                sda_oe_o <= 1'b0;
            end else if (start_ev) begin
                state_r <= ST_DEVADR;
                bit_cnt_r <= 4'h0;
                sda_oe_o <= 1'b0;
            end else begin
                case (state_r)
                ST_IDLE: begin
                    // Standby: line released, counter kept
                    sda_oe_o <= 1'b0;
                end
                ST_DEVADR, ST_WADDR, ST_WDATA: begin
                    if (scl_rise) begin
                        shift_r <= {shift_r[6:0], sda_s_r};
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end else if (scl_fall && bit_cnt_r == 4'h8) begin
                        bit_cnt_r <= 4'h0;
                        if (state_r == ST_DEVADR) begin
                            if (dev_match(shift_r, chip_sel_i)) begin
                                if (PAGE_SEL_BITS > 0) begin
                                    addr_r[AW-1:LOW_BITS] <=
                                        shift_r[PAGE_SEL_BITS:1];
                                end
                                ack_next_r <= shift_r[`DEV_RW_BIT] ?
                                    2'h1 : 2'h2;
                                sda_oe_o <= 1'b1;
                                state_r <= ST_ACK;
                                if (shift_r[`DEV_RW_BIT]) begin
                                    mem_addr_o <= sel_addr;
                                    mem_rd_o <= 1'b1;
                                end
                            end else begin
                                state_r <= ST_IDLE;
                            end
                        end else if (state_r == ST_WADDR) begin
                            // Dummy write loads the counter here
                            addr_r[LOW_BITS-1:0] <=
                                shift_r[LOW_BITS-1:0];
                            ack_next_r <= 2'h3;
                            sda_oe_o <= 1'b1;
                            state_r <= ST_ACK;
                        end else if (fifo_in_ready) begin
                            fifo_in_data_r <= {addr_r, shift_r};
                            fifo_in_valid_r <= 1'b1;
                            addr_r <= write_next(addr_r);
                            ack_next_r <= 2'h3;
                            sda_oe_o <= 1'b1;
                            state_r <= ST_ACK;
                        end else begin
                            // Full buffer: withhold ack, wait for stop
                            state_r <= ST_IDLE;
                        end
                    end
                end
                ST_ACK: begin
                    // Data is picked up at the fall that ends the ack bit
                    if (scl_fall) begin
                        sda_oe_o <= 1'b0;
                        case (ack_next_r)
                        2'h1: begin
                            tx_r <= mem_data_i;
                            addr_r <= read_next(addr_r);
                            state_r <= ST_RDATA;
                            sda_oe_o <= !mem_data_i[7];
                        end
                        2'h2: state_r <= ST_WADDR;
                        default: state_r <= ST_WDATA;
                        endcase
                    end
                end
                ST_RDATA: begin
                    // Bits move on the fall so they stand while clock is high
                    if (scl_fall) begin
                        if (bit_cnt_r == 4'h7) begin
                            bit_cnt_r <= 4'h0;
                            sda_oe_o <= 1'b0;
                            state_r <= ST_MACK;
                        end else begin
                            bit_cnt_r <= bit_cnt_r + 4'h1;
                            tx_r <= {tx_r[6:0], 1'b1};
                            sda_oe_o <= !tx_r[6];
                        end
                    end
                end
                ST_MACK: begin
                    // Master's answer is read while the clock is high
                    if (scl_rise) begin
                        if (!sda_s_r) begin
                            mem_addr_o <= addr_r;
                            mem_rd_o <= 1'b1;
                            state_r <= ST_FETCH;
                        end else begin
                            // Master nack: wait for stop
                            state_r <= ST_IDLE;
                        end
                    end
                end
                ST_FETCH: begin
                    // Next word leaves on the fall that ends the ack bit
                    if (scl_fall) begin
                        tx_r <= mem_data_i;
                        addr_r <= read_next(addr_r);
                        sda_oe_o <= !mem_data_i[7];
                        state_r <= ST_RDATA;
                    end
                end
                default: state_r <= ST_IDLE;
                endcase
            end
        end
    end

    // ------------------------------------------------
    // Write stream output stage
    // ------------------------------------------------
    // Entry is held while the array stalls; a new one follows its taking
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wr_valid_o <= 1'b0;
            wr_addr_o <= `ADDR_RESET;
            wr_data_o <= 8'h00;
        end else if (fifo_take) begin
            wr_valid_o <= 1'b1;
            wr_addr_o <= fifo_out_data[AW+7:8];
            wr_data_o <= fifo_out_data[7:0];
        end else if (wr_ready_i) begin
            wr_valid_o <= 1'b0;
        end
    end
endmodule // eeprom_read_engine

/* File: sim/serial_eeprom_checker_assertions.sv */
`timescale 1ns/1ps
module serial_eeprom_checker #(
    parameter AW = 11
) (
    // Clock and reset
    input wire clk_i,
    input wire arst_n_i,
    // Bus pins
    input wire scl_i,
    input wire sda_o,
    input wire sda_oe_o,
    // Array side
    input wire [AW-1:0] mem_addr_o,
    input wire mem_rd_o,
    input wire wr_valid_o,
    input wire [AW-1:0] wr_addr_o,
    input wire [7:0] wr_data_o,
    input wire wr_ready_i,
    // Status
    input wire busy_o,
    input wire [AW-1:0] addr_cnt_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!arst_n_i);
    // ------------------------------
    // Bus pin behaviour
    // ------------------------------
    a_open_drain: assert property (sda_o == 1'b0)
        else $error("data pin value not low");
    // Output bits may only move while the clock has been low a while
    a_oe_scl_low: assert property ($changed(sda_oe_o) |->
        !scl_i && !$past(scl_i) && !$past(scl_i, 2))
        else $error("data pin changed outside clock low");
    a_busy_drive: assert property (sda_oe_o |-> busy_o)
        else $error("pin driven while idle");
    // ------------------------------
    // Address counter
    // ------------------------------
    a_rd_single: assert property (mem_rd_o |=> !mem_rd_o)
        else $error("array read pulse too long");
    a_cnt_follow: assert property (mem_rd_o |->
        ##[0:16] addr_cnt_o == mem_addr_o + 1'b1)
        else $error("counter not read address plus one");
    a_cnt_hold: assert property (!busy_o && !$past(busy_o)
        && !$past(busy_o, 2) |-> $stable(addr_cnt_o))
        else $error("counter moved while idle");
    // ------------------------------
    // Write stream
    // ------------------------------
    a_wr_page: assert property (wr_valid_o && wr_ready_i ##1
        wr_valid_o |-> wr_addr_o[3:0] == $past(wr_addr_o[3:0]) + 4'h1
        && wr_addr_o[AW-1:4] == $past(wr_addr_o[AW-1:4]))
        else $error("write address left its page");
    a_wr_hold: assert property (wr_valid_o && !wr_ready_i |=>
        wr_valid_o && $stable(wr_addr_o) && $stable(wr_data_o))
        else $error("write entry dropped while stalled");
    c_read: cover property (mem_rd_o);
    c_stall: cover property (wr_valid_o && !wr_ready_i);
    c_wrap: cover property (&$past(addr_cnt_o) && addr_cnt_o == '0);
endmodule // serial_eeprom_checker

/* File: sim/two_wire_master_model.sv */
`timescale 1ns/1ps
module two_wire_master_model (
    // Clock and bus
    input wire clk_i,
    input wire sda_i,
    output logic scl_o,
    output logic sda_low_o
);
    // Quarter bit; pins move on the falling clock edge only
    task automatic q_wait();
        repeat (2) @(negedge clk_i);
    endtask
    task automatic start();
        sda_low_o = 1'b0;
        q_wait();
        scl_o = 1'b1;
        q_wait();
        sda_low_o = 1'b1;
        q_wait();
        scl_o = 1'b0;
        q_wait();
    endtask
    // Clock is left high afterwards: it stands still between frames
    task automatic stop();
        sda_low_o = 1'b1;
        q_wait();
        scl_o = 1'b1;
        q_wait();
        sda_low_o = 1'b0;
        q_wait();
    endtask
    task automatic bit_xfer(input logic low, output logic seen);
        sda_low_o = low;
        q_wait();
        scl_o = 1'b1;
        q_wait();
        seen = sda_i;
        q_wait();
        scl_o = 1'b0;
        q_wait();
    endtask
    task automatic wr_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_xfer(!b[i], s);
        bit_xfer(1'b0, s);
        ack = !s;
    endtask
    task automatic rd_byte(input logic ack_it, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(1'b0, s);
            b[i] = s;
        end
        bit_xfer(ack_it, s);
    endtask
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
endmodule // two_wire_master_model

/* File: sim/serial_eeprom_read_engine_tb_top.sv */
`timescale 1ns/1ps
module serial_eeprom_read_engine_tb_top;
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic wr_ready_i = 1'b0;
    logic scl, sda_low, sda_o, sda_oe_o, mem_rd_o, wr_valid_o, busy_o;
    logic [10:0] mem_addr_o, wr_addr_o, addr_cnt_o;
    logic [7:0] mem_data_i, wr_data_o;
    logic sda;
    int miscompares = 0;
    int check_count = 0;
    logic [10:0] wq_a[$];
    logic [7:0] wq_d[$];
    always #50 clk_i = ~clk_i;
    // Pull-up: the line is low while any party pulls it
    assign sda = !(sda_low || (sda_oe_o && !sda_o));
    function automatic logic [7:0] exp_data(input logic [10:0] a);
        return a[7:0] ^ {5'h00, a[10:8]} ^ 8'hC3;
    endfunction
    assign mem_data_i = exp_data(mem_addr_o);
    always @(posedge clk_i) begin
        if (wr_valid_o && wr_ready_i) begin
            wq_a.push_back(wr_addr_o);
            wq_d.push_back(wr_data_o);
        end
    end
    two_wire_master_model u_master (.clk_i(clk_i), .sda_i(sda),
        .scl_o(scl), .sda_low_o(sda_low));
    eeprom_read_engine DUT (.clk_i(clk_i), .arst_n_i(arst_n_i),
        .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
        .chip_sel_i(3'h0), .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o),
        .mem_data_i(mem_data_i), .wr_valid_o(wr_valid_o),
        .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o),
        .wr_ready_i(wr_ready_i), .busy_o(busy_o), .addr_cnt_o(addr_cnt_o));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Dummy write: loads the word address, sends no data
    task automatic set_addr(input logic [10:0] a);
        logic ack;
        u_master.start();
        u_master.wr_byte({4'hA, a[10:8], 1'b0}, ack);
        chk(16'(ack), 16'h0001);
        u_master.wr_byte(a[7:0], ack);
        chk(16'(ack), 16'h0001);
        chk(16'(busy_o), 16'h0001);
    endtask
    task automatic read_run(input logic [10:0] a, input int n);
        logic ack;
        logic [7:0] d;
        u_master.start();
        u_master.wr_byte({4'hA, a[10:8], 1'b1}, ack);
        chk(16'(ack), 16'h0001);
        for (int i = 0; i < n; i++) begin
            u_master.rd_byte(i < n - 1, d);
            chk(16'(d), 16'(exp_data(a + i[10:0])));
        end
        u_master.stop();
        chk(16'(addr_cnt_o), 16'(11'(a + n[10:0])));
    endtask
    task automatic t_current();
        chk(16'(addr_cnt_o), 16'h0000);
        read_run(11'h000, 1);
        repeat (20) @(negedge clk_i);
        chk(16'(busy_o), 16'h0000);
        read_run(11'h001, 1);
    endtask
    task automatic t_random();
        set_addr(11'h5A3);
        read_run(11'h5A3, 1);
    endtask
    task automatic t_seq_wrap();
        set_addr(11'h7FE);
        read_run(11'h7FE, 3);
    endtask
    task automatic t_bad_type();
        logic ack;
        u_master.start();
        u_master.wr_byte(8'h51, ack);
        chk(16'(ack), 16'h0000);
        u_master.stop();
        chk(16'(addr_cnt_o), 16'h0001);
    endtask
    // Array stalls until the buffer refuses a byte, then drains it
    task automatic t_write_fill();
        logic ack;
        int n;
        wr_ready_i = 1'b0;
        set_addr(11'h01F);
        n = 0;
        ack = 1'b1;
        while (ack && n < 10) begin
            u_master.wr_byte(8'h40 + n[7:0], ack);
            if (ack) n++;
        end
        u_master.stop();
        chk(16'(n >= 8 && n <= 9), 16'h0001);
        wr_ready_i = 1'b1;
        for (int w = 0; w < 200 && wq_a.size() < n; w++) @(posedge clk_i);
        chk(16'(wq_a.size()), 16'(n));
        for (int k = 0; k < n && k < wq_a.size(); k++) begin
            chk(16'(wq_a[k]), {5'h00, 7'h01, 4'hF + k[3:0]});
            chk(16'(wq_d[k]), 16'(8'h40 + k[7:0]));
        end
    endtask
    task automatic wrap_up();
        $display("checks=%0d miscompares=%0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk_i);
        @(negedge clk_i);
        arst_n_i = 1'b1;
        t_current();
        t_random();
        t_seq_wrap();
        t_bad_type();
        t_write_fill();
        wrap_up();
    end
    initial begin
        repeat (40000) @(posedge clk_i);
        miscompares++;
        wrap_up();
    end
endmodule // serial_eeprom_read_engine_tb_top
bind eeprom_read_engine serial_eeprom_checker #(.AW(AW)) u_chk (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .scl_i(scl_i), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o),
    .wr_valid_o(wr_valid_o), .wr_addr_o(wr_addr_o),
    .wr_data_o(wr_data_o), .wr_ready_i(wr_ready_i), .busy_o(busy_o),
    .addr_cnt_o(addr_cnt_o));
